//--- tb/dual_gpio_port_change_irq_bench.sv
// self-checking bench of the dual gpio port block
module dual_gpio_port_change_irq_bench import gpio_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// write flag, offset, data or expected read
	typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} row_t;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
	logic [4:0] first_ext = 5'h0A;
	logic [7:0] second_ext = 8'h00, second_ext_en = 8'hFF;
	dir_override_t second_override = '0;
	wire logic hready, hreadyout, hresp, irq, wake;
	wire logic [31:0] hrdata;
	wire logic [4:0] first_pin_in, first_pin_out, first_pin_oe;
	wire logic [2:0] analog_pin_select;
	wire logic [7:0] second_pin_in, second_pin_out, second_pin_oe, second_pullup_en;
	int failures = 0, tests_run = 0, cycles = 0;
	row_t rows[$] = '{17'h0041F, 17'h010FF, 17'h014FF, 17'h00800, 17'h02000, 17'h01800,
		17'h1040A, 17'h0040A, 17'h10805, 17'h00805, 17'h1100F, 17'h0100F, 17'h1147F,
		17'h0147F, 17'h124FF, 17'h02400, 17'h11801, 17'h01800, 17'h01C00, 17'h10015,
		17'h10CA5, 17'h12001, 17'h0001F, 17'h00CA0};
	assign hready = hreadyout;
	always #50 hclk = ~hclk;
	dual_gpio_port_change_irq u_dut (.*);
	gpio_pins_model u_pins (.*);
	task automatic chk(input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : cyc
	// one single ahb-lite transfer, reads compared
	task automatic bus(input row_t x);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, x.a};
		hwrite <= x.w;
		do @(posedge hclk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= {24'h0, x.d};
		do @(posedge hclk); while (hready !== 1'h1);
		r = hrdata;
		if (!x.w) chk(r, {24'h0, x.d});
	endtask : bus
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// cut a hung run short
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			wrap_up();
		end
	end
	// main sequence
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'h1;
		foreach (rows[i]) bus(rows[i]); // resets, access kinds
		cyc(2);
		chk(first_pin_oe, 5'h15); // first directions
		chk(analog_pin_select, 3'h5); // analog field
		chk({second_pin_oe, second_pin_out}, 16'hF0A5); // drive from latch
		chk(second_pullup_en, 8'h0F); // inputs only
		@(posedge hclk);
		second_ext_en <= 8'h00;
		bus(17'h110FF);
		cyc(4);
		chk({irq, wake}, 2'h3); // change raised
		bus(17'h11C01);
		bus(17'h01801); // flag persists
		bus(17'h12000);
		cyc(2);
		chk({irq, wake}, 2'h1); // masked irq
		bus(17'h00CFF); // snapshot refresh
		bus(17'h11C01);
		bus(17'h01800); // cleared
		bus(17'h12001);
		bus(17'h1100F);
		bus(17'h10C50);
		second_ext_en <= 8'h0F;
		cyc(4);
		bus(17'h01800); // outputs and low pins ignored
		second_override <= '{8'h01, 8'h80};
		cyc(2);
		chk(second_pin_oe, 8'h71); // forced pins
		bus(17'h0100F); // stored value kept
		bus(17'h01800); // no false change on forced turn
		second_override <= '0;
		hresetn <= 1'h0;
		cyc(2);
		chk({second_pin_oe, second_pullup_en, irq}, 17'h0); // in reset
		@(posedge hclk);
		hresetn <= 1'h1;
		bus(17'h014FF); // pull-ups off again
		wrap_up();
	end
endmodule : dual_gpio_port_change_irq_bench

//--- tb/dual_gpio_port_change_irq_props.sv
// assertion checker for the dual gpio port block
module dual_gpio_port_change_irq_props import gpio_pkg::*; (
	// clock, reset and bus
	input wire logic          hclk,
	input wire logic          hresetn,
	input wire logic          hsel,
	input wire logic [31:0]   haddr,
	input wire logic [1:0]    htrans,
	input wire logic          hwrite,
	input wire logic [31:0]   hrdata,
	input wire logic          hreadyout,
	input wire logic          hresp,
	// second port and events
	input wire dir_override_t second_override,
	input wire logic [7:0]    second_pin_oe,
	input wire logic [7:0]    second_pullup_en,
	input wire logic          irq,
	input wire logic          wake
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// a read taken on the bus
	sequence s_read;
		hsel && htrans[1] && !hwrite;
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer wrong");
	a_force_out: assert property ((second_pin_oe & $past(second_override.force_out)) ==
		$past(second_override.force_out)) else $error("forced output not driven");
	a_force_in: assert property ((second_pin_oe & $past(second_override.force_in
		& ~second_override.force_out)) == 8'h00) else $error("forced input driven");
	a_pullup_outputs: assert property ((second_pullup_en & second_pin_oe) == 8'h00)
		else $error("pull-up on output");
	a_pullup_global: assert property (second_pullup_en == 8'h00 ||
		second_pullup_en == ~second_pin_oe) else $error("pull-ups not global");
	a_irq_wake: assert property (irq |-> wake) else $error("irq without wake");
	a_wake_clear: assert property ($fell(wake) |-> $past(hsel && htrans[1] && hwrite &&
		haddr[7:0] == 8'h1C, 3)) else $error("flag dropped without clear");
	a_read_upper: assert property (s_read |=> hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
endmodule : dual_gpio_port_change_irq_props

bind dual_gpio_port_change_irq dual_gpio_port_change_irq_props u_props (.*);

//--- tb/gpio_pins_model.sv
// pin-level model of the parties outside both gpio ports
module gpio_pins_model (
	// clock
	input wire logic       hclk,
	// levels from the block
	input wire logic [4:0] first_pin_out,
	input wire logic [4:0] first_pin_oe,
	input wire logic [7:0] second_pin_out,
	input wire logic [7:0] second_pin_oe,
	input wire logic [7:0] second_pullup_en,
	// outside drivers
	input wire logic [4:0] first_ext,
	input wire logic [7:0] second_ext,
	input wire logic [7:0] second_ext_en,
	// resolved levels
	output logic     [4:0] first_pin_in,
	output logic     [7:0] second_pin_in
);
	logic [7:0] flt = 8'h00;
	logic [7:0] idle;
	// an undriven line without pull-up wanders every cycle
	always @(posedge hclk) flt <= ~flt;
	// outside driver, else pull-up, else wander
	assign idle = second_ext_en & second_ext | ~second_ext_en & (second_pullup_en | flt);
	// block driver wins where enabled
	assign second_pin_in = second_pin_oe & second_pin_out | ~second_pin_oe & idle;
	assign first_pin_in = first_pin_oe & first_pin_out | ~first_pin_oe & first_ext;
endmodule : gpio_pins_model

//--- verilog/dual_gpio_port_change_irq.sv
// dual gpio port with weak pull-up control and change interrupt, ahb-lite slave
//
// Overview of operation
// - second port: eight pins, own direction bits
// - direction one makes second-port pin input
// - direction zero drives second-port output latch
// - cleared global bit enables all pull-ups
// - pull-up off on output pins
// - pull-ups disabled after reset
// - peripheral may force direction out or in
// - change watch on upper four input pins
// - compare against snapshot from last read
// - OR of mismatches sets change flag
// - change event wakes device from sleep
// - mismatch keeps setting flag until read
// - first port: five pins, one is input; here all five take their direction from first_dir
// - first port reads pins, writes latch
// - low four first-port pins analog capable
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`include "gpio_params.svh"

module dual_gpio_port_change_irq
	import gpio_pkg::*;
#(
	parameter int FIRST_WIDTH  = 5,
	parameter int SECOND_WIDTH = 8
) (
	// clock and reset
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	// ahb-lite slave
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic      [31:0]             hrdata,
	output logic                         hreadyout,
	output logic                         hresp,
	// first port pins
	input  wire logic [FIRST_WIDTH-1:0]  first_pin_in,
	output logic      [FIRST_WIDTH-1:0]  first_pin_out,
	output logic      [FIRST_WIDTH-1:0]  first_pin_oe,
	output logic      [2:0]              analog_pin_select,
	// second port pins
	input  wire logic [SECOND_WIDTH-1:0] second_pin_in,
	output logic      [SECOND_WIDTH-1:0] second_pin_out,
	output logic      [SECOND_WIDTH-1:0] second_pin_oe,
	output logic      [SECOND_WIDTH-1:0] second_pullup_en,
	// peripheral overrides of second port direction
	input  wire dir_override_t           second_override,
	// interrupt and wake
	output logic                         irq,
	output logic                         wake
);

	// elaboration check
	if (FIRST_WIDTH != 5 || SECOND_WIDTH != 8) begin : g_bad_width
		$error("port widths must be 5 and 8");
	end

	// software state
	logic [FIRST_WIDTH-1:0]  first_latch;
	logic [FIRST_WIDTH-1:0]  first_dir;
	logic [2:0]              analog_cfg;
	logic [SECOND_WIDTH-1:0] second_latch;
	logic [SECOND_WIDTH-1:0] second_dir;
	logic [7:0]              option_settings;
	logic                    irq_status;
	logic                    irq_enable;
	logic [3:0]              snapshot;
	ahb_phase_t              phase;

	// address phase decode
	wire        take     = hsel & hready & htrans[1];
	wire        wr_go    = phase.valid & phase.write;
	wire        rd_now   = take & ~hwrite;
	wire [7:0]  cur_addr = haddr[7:0];
	wire        rd_second = rd_now & (cur_addr == `OFS_SECOND_PORT_DATA);

	// effective second-port direction after peripheral overrides
	wire [SECOND_WIDTH-1:0] eff_dir =
		(second_dir | second_override.force_in) & ~second_override.force_out;

	// change detection on watched input pins
	wire [3:0] watch_in  = second_pin_in[`WATCH_HI:`WATCH_LO];
	// direction as applied at the pins: a pin turning input still shows its
	// driven level for one cycle, so the registered enable gates the compare
	wire [3:0] watch_dir = ~second_pin_oe[`WATCH_HI:`WATCH_LO];
	wire [3:0] mismatch  = (watch_in ^ snapshot) & watch_dir;
	wire       change    = |mismatch;

	// write decode in data phase
	wire wr_first  = wr_go & (phase.addr == `OFS_FIRST_PORT_DATA);
	wire wr_fdir   = wr_go & (phase.addr == `OFS_FIRST_PORT_DIR);
	wire wr_analog = wr_go & (phase.addr == `OFS_ANALOG_PIN_CONFIG);
	wire wr_second = wr_go & (phase.addr == `OFS_SECOND_PORT_DATA);
	wire wr_sdir   = wr_go & (phase.addr == `OFS_SECOND_PORT_DIR);
	wire wr_option = wr_go & (phase.addr == `OFS_OPTION_SETTINGS);
	wire wr_clear  = wr_go & (phase.addr == `OFS_IRQ_CLEAR);
	wire wr_enable = wr_go & (phase.addr == `OFS_IRQ_ENABLE);

	// read mux, pins read live
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (cur_addr)
			`OFS_FIRST_PORT_DATA:   rd_mux[FIRST_WIDTH-1:0] = first_pin_in;
			`OFS_FIRST_PORT_DIR:    rd_mux[FIRST_WIDTH-1:0] = first_dir;
			`OFS_ANALOG_PIN_CONFIG: rd_mux[2:0] = analog_cfg;
			`OFS_SECOND_PORT_DATA:  rd_mux[7:0] = second_pin_in;
			`OFS_SECOND_PORT_DIR:   rd_mux[7:0] = second_dir;
			`OFS_OPTION_SETTINGS:   rd_mux[7:0] = option_settings;
			`OFS_IRQ_STATUS:        rd_mux[`BIT_IRQ_PORT_CHANGE] = irq_status;
			`OFS_IRQ_ENABLE:        rd_mux[`BIT_IRQ_PORT_CHANGE] = irq_enable;
			default:                rd_mux = 32'h0000_0000;
		endcase
	end

	// bus phase tracking and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase     <= '0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			phase.valid <= take;
			phase.write <= hwrite;
			phase.addr  <= cur_addr;
			if (rd_now) begin
				hrdata <= rd_mux;
			end
		end
	end

	// control registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_latch     <= FIRST_WIDTH'(`RST_LATCH);
			first_dir       <= `RST_FIRST_PORT_DIR;
			analog_cfg      <= `RST_ANALOG_PIN_CONFIG;
			second_latch    <= `RST_LATCH;
			second_dir      <= `RST_SECOND_PORT_DIR;
			option_settings <= `RST_OPTION_SETTINGS;
			irq_enable      <= 1'b0;
		end else begin
			if (wr_first)  first_latch     <= hwdata[FIRST_WIDTH-1:0];
			if (wr_fdir)   first_dir       <= hwdata[FIRST_WIDTH-1:0];
			if (wr_analog) analog_cfg      <= hwdata[2:0];
			if (wr_second) second_latch    <= hwdata[7:0];
			if (wr_sdir)   second_dir      <= hwdata[7:0];
			if (wr_option) option_settings <= hwdata[7:0];
			if (wr_enable) irq_enable      <= hwdata[`BIT_IRQ_PORT_CHANGE];
		end
	end

	// snapshot refreshed on each read of second port
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			snapshot <= 4'h0;
		end else if (rd_second) begin
			snapshot <= watch_in;
		end
	end

	// sticky change flag, set beats clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= 1'b0;
		end else if (change) begin
			irq_status <= 1'b1;
		end else if (wr_clear && hwdata[`BIT_IRQ_PORT_CHANGE]) begin
			irq_status <= 1'b0;
		end
	end

	// registered pin drive, pull-ups, interrupt and wake
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_pin_out     <= '0;
			first_pin_oe      <= '0;
			analog_pin_select <= 3'h0;
			second_pin_out    <= '0;
			second_pin_oe     <= '0;
			second_pullup_en  <= '0;
			irq               <= 1'b0;
			wake              <= 1'b0;
		end else begin
			first_pin_out     <= first_latch;
			first_pin_oe      <= ~first_dir;
			analog_pin_select <= analog_cfg;
			second_pin_out    <= second_latch;
			second_pin_oe     <= ~eff_dir;
			second_pullup_en  <= eff_dir & {SECOND_WIDTH{~option_settings[`BIT_PULLUP_DISABLE_N]}};
			irq               <= irq_status & irq_enable;
			wake              <= irq_status;
		end
	end

endmodule : dual_gpio_port_change_irq

//--- verilog/gpio_params.svh
// register offsets, field positions and reset values of the dual gpio port block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

`define OFS_FIRST_PORT_DATA    8'h00
`define OFS_FIRST_PORT_DIR     8'h04
`define OFS_ANALOG_PIN_CONFIG  8'h08
`define OFS_SECOND_PORT_DATA   8'h0C
`define OFS_SECOND_PORT_DIR    8'h10
`define OFS_OPTION_SETTINGS    8'h14
`define OFS_IRQ_STATUS         8'h18
`define OFS_IRQ_CLEAR          8'h1C
`define OFS_IRQ_ENABLE         8'h20

`define RST_FIRST_PORT_DIR     5'h1F
`define RST_ANALOG_PIN_CONFIG  3'h0
`define RST_SECOND_PORT_DIR    8'hFF
`define RST_OPTION_SETTINGS    8'hFF
`define RST_LATCH              8'h00

`define BIT_PULLUP_DISABLE_N   7
`define BIT_IRQ_PORT_CHANGE    0
`define WATCH_LO               4
`define WATCH_HI               7

`endif

//--- verilog/gpio_pkg.sv
// types shared by the dual gpio port block
package gpio_pkg;

	// one ahb-lite address phase captured for its data phase
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} ahb_phase_t;

	// peripheral override of one port's directions
	typedef struct packed {
		logic [7:0] force_out;
		logic [7:0] force_in;
	} dir_override_t;

endpackage : gpio_pkg
